// ==== rtl/dmps_pkg.sv ====
/*
  Shared constants for the drive motion parameter set: register indices, reset values,
  interrupt bit layout, start-phase states and timing figures.
  Assumes a 125 MHz system clock and an APB master addressing one 32-bit word per register.
*/
// Behaviour
// - Flag drag error when following error exceeds threshold.
// - Readjustment at standstill off at 0, on at 1.
// - Clamp speed correction to configured limit, default 4.
// - Correction limit changes accepted only at standstill.
// - Each jog event moves configured increments, default 1.
// - Positioning runs capped at positioning target speed.
// - Manual runs capped at manual target speed.
// - Abort threshold is percent of target, default 30.
// - Ramp with separate acceleration and deceleration rates.
// - Start-up torque during start phase, then running torque.
// - Torque command never exceeds active torque limit.
// - Start phase lasts configured milliseconds, default 200.
package dmps_pkg;

  // ----------------------------------------------------------------------
  // Register indices; byte address is four times the index.
  // ----------------------------------------------------------------------
  localparam logic [7:0] IDX_DRAG_THR = 8'h2E;
  localparam logic [7:0] IDX_READJUST = 8'h2F;
  localparam logic [7:0] IDX_CORR_LIM = 8'h30;
  localparam logic [7:0] IDX_JOG_STEP = 8'h31;
  localparam logic [7:0] IDX_POS_SPEED = 8'h35;
  localparam logic [7:0] IDX_MAN_SPEED = 8'h38;
  localparam logic [7:0] IDX_ABORT_PCT = 8'h39;
  localparam logic [7:0] IDX_ACCEL = 8'h3A;
  localparam logic [7:0] IDX_DECEL = 8'h3B;
  localparam logic [7:0] IDX_START_TQ = 8'h3F;
  localparam logic [7:0] IDX_RUN_TQ = 8'h40;
  localparam logic [7:0] IDX_START_TIME = 8'h47;
  localparam logic [7:0] IDX_IRQ_STAT = 8'h60;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h61;
  localparam logic [7:0] IDX_MOTION = 8'h62;

  // ----------------------------------------------------------------------
  // Parameter bank slots and their reset values.
  // ----------------------------------------------------------------------
  localparam int NSLOT = 12;
  localparam logic [3:0] SLOT_DRAG = 4'h0;
  localparam logic [3:0] SLOT_READJ = 4'h1;
  localparam logic [3:0] SLOT_CORR = 4'h2;
  localparam logic [3:0] SLOT_JOG = 4'h3;
  localparam logic [3:0] SLOT_POSSPD = 4'h4;
  localparam logic [3:0] SLOT_MANSPD = 4'h5;
  localparam logic [3:0] SLOT_ABORT = 4'h6;
  localparam logic [3:0] SLOT_ACCEL = 4'h7;
  localparam logic [3:0] SLOT_DECEL = 4'h8;
  localparam logic [3:0] SLOT_STQ = 4'h9;
  localparam logic [3:0] SLOT_RTQ = 4'hA;
  localparam logic [3:0] SLOT_STIME = 4'hB;
  localparam logic [3:0] SLOT_IRQS = 4'hC;
  localparam logic [3:0] SLOT_IRQM = 4'hD;
  localparam logic [3:0] SLOT_MOTION = 4'hE;
  localparam logic [3:0] SLOT_NONE = 4'hF;
  localparam logic [15:0] RST_VALS [NSLOT] = '{16'h0000, 16'h0000, 16'h0004, 16'h0001,
    16'h0BB8, 16'h03E8, 16'h001E, 16'h2710, 16'h2710, 16'h0064, 16'h0064, 16'h00C8};

  // ----------------------------------------------------------------------
  // Interrupt status bits.
  // ----------------------------------------------------------------------
  localparam int IRQ_W = 3;
  localparam int IRQ_DRAG = 0;
  localparam int IRQ_START_DONE = 1;
  localparam int IRQ_JOG = 2;

  // ----------------------------------------------------------------------
  // Timing: one millisecond tick and unit conversions.
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 8;
  localparam int MS_NS = 1000000;
  localparam int CYC_PER_MS = MS_NS / CLK_PERIOD_NS;
  localparam logic [9:0] MRPM_PER_RPM = 10'h3E8;
  localparam logic [6:0] PCT_FULL = 7'h64;

  // Start phase states, one-hot.
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_START = 3'b010,
    ST_RUN = 3'b100
  } dmps_phase_t;

endpackage

// ==== rtl/dmps_motion_params.sv ====
/*
  Motion parameter set of a positioning drive: APB register bank, drag error monitor,
  speed ramp with caps, correction clamp, jog steps, start-phase torque selection, interrupt.
  Assumes the position loop, run state and torque demand come from logic on clk, and the
  external jog key arrives asynchronously from a pin.
*/
`timescale 1ns/10ps
module dmps_motion_params
  import dmps_pkg::*;
#(
  parameter int ADDR_W = 12,
  parameter int TICK_CYCLES = CYC_PER_MS
)
(
  // Clock and reset.
  input wire logic clk,
  input wire logic sys_rst,
  // APB slave.
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Position loop and run state.
  input wire logic signed [31:0] cmdPos,
  input wire logic signed [31:0] actPos,
  input wire logic runActive,
  input wire logic manualRun,
  input wire logic atStandstill,
  input wire logic signed [15:0] corrRequest,
  input wire logic [15:0] torqueDemand,
  // Jog sources.
  input wire logic jogKeyPin,
  input wire logic jogBit,
  // Drive outputs.
  output logic dragError,
  output logic readjustEnable,
  output logic signed [15:0] speedCorr,
  output logic [31:0] speedCmdMrpm,
  output logic [15:0] abortSpeedRpm,
  output logic [15:0] torqueLimit,
  output logic [15:0] torqueCmd,
  output logic startPhase,
  output logic jogStrobe,
  output logic [15:0] jogDistance,
  output logic irq
);

  // ----------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------
  // Maps a word index to a bank slot; unknown indices give SLOT_NONE.
  function automatic logic [3:0] slotOf(input logic [ADDR_W-1:0] a);
    logic [7:0] idx;
    idx = a[9:2];
    slotOf = SLOT_NONE;
    if (a[ADDR_W-1:10] == '0 && a[1:0] == 2'b00)
    begin
      unique case (idx)
        IDX_DRAG_THR: slotOf = SLOT_DRAG;
        IDX_READJUST: slotOf = SLOT_READJ;
        IDX_CORR_LIM: slotOf = SLOT_CORR;
        IDX_JOG_STEP: slotOf = SLOT_JOG;
        IDX_POS_SPEED: slotOf = SLOT_POSSPD;
        IDX_MAN_SPEED: slotOf = SLOT_MANSPD;
        IDX_ABORT_PCT: slotOf = SLOT_ABORT;
        IDX_ACCEL: slotOf = SLOT_ACCEL;
        IDX_DECEL: slotOf = SLOT_DECEL;
        IDX_START_TQ: slotOf = SLOT_STQ;
        IDX_RUN_TQ: slotOf = SLOT_RTQ;
        IDX_START_TIME: slotOf = SLOT_STIME;
        IDX_IRQ_STAT: slotOf = SLOT_IRQS;
        IDX_IRQ_MASK: slotOf = SLOT_IRQM;
        IDX_MOTION: slotOf = SLOT_MOTION;
        default: slotOf = SLOT_NONE;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------------
  // State declarations
  // ----------------------------------------------------------------------
  logic [15:0] bank_q [NSLOT]; // Parameter bank.
  logic [15:0] bank_d [NSLOT];
  logic [IRQ_W-1:0] irqStat_q, irqStat_d; // Sticky events.
  logic [IRQ_W-1:0] irqMask_q, irqMask_d; // Interrupt enables.
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pready_d, pslverr_q, pslverr_d; // Bus answer.
  logic jogMeta_q, jogSync_q, jogPrev_q; // Jog key synchroniser.
  dmps_phase_t phase_q, phase_d; // Start phase tracker.
  logic [31:0] tickCnt_q, tickCnt_d; // Cycles within one millisecond.
  logic [15:0] msCnt_q, msCnt_d; // Milliseconds into start phase.
  logic [31:0] speed_q, speed_d; // Ramped speed in milli-rpm.
  logic dragErr_q, dragErr_d, readj_q, readj_d; // Drag flag and readjust enable.
  logic signed [15:0] corr_q, corr_d;
  logic [15:0] abort_q, abort_d, tqLim_q, tqLim_d, tqCmd_q, tqCmd_d; // Abort speed, torques.
  logic startPh_q, startPh_d, jogStb_q, jogStb_d; // Start phase and jog strobe.
  logic [15:0] jogDist_q, jogDist_d;
  logic irq_q, irq_d;

  // Shared combinational terms.
  logic [3:0] slot; // Decoded slot of the current address.
  logic wrDone; // Write completes at this edge.
  logic msTick; // One-cycle pulse each millisecond.
  logic [15:0] tgtRpm; // Active speed cap.
  logic [31:0] tgtMrpm; // Cap in milli-rpm.
  logic [32:0] posDiff; // Signed following error.
  logic [32:0] posMag; // Its magnitude.
  logic jogEvent; // Key edge or jog bit.

  assign slot = slotOf(paddr);
  assign wrDone = psel & penable & pready_q & pwrite;
  assign msTick = (tickCnt_q == 32'(TICK_CYCLES - 1));
  assign jogEvent = (jogSync_q & ~jogPrev_q) | jogBit;

  // ----------------------------------------------------------------------
  // APB slave and register bank
  // ----------------------------------------------------------------------
  // Registered zero-wait answer: pready rises in the first access cycle.
  always_comb
  begin
    bank_d = bank_q;
    irqMask_d = irqMask_q;
    prdata_d = prdata_q;
    pslverr_d = 1'b0;
    pready_d = psel & ~penable;
    if (psel & ~penable)
    begin
      prdata_d = 32'h00000000;
      pslverr_d = (slot == SLOT_NONE);
      if (slot < SLOT_IRQS)
        prdata_d = {16'h0000, bank_q[slot]};
      else if (slot == SLOT_IRQS)
        prdata_d = {{(32-IRQ_W){1'b0}}, irqStat_q};
      else if (slot == SLOT_IRQM)
        prdata_d = {{(32-IRQ_W){1'b0}}, irqMask_q};
      else if (slot == SLOT_MOTION)
        prdata_d = {26'h0000000, jogStb_q, dragErr_q, phase_q, atStandstill};
    end
    if (wrDone && slot < SLOT_IRQS)
    begin
      // Correction limit is frozen while the axis moves.
      if (slot != SLOT_CORR || atStandstill)
        bank_d[slot] = pwdata[15:0];
    end
    if (wrDone && slot == SLOT_IRQM)
      irqMask_d = pwdata[IRQ_W-1:0];
  end

  // Registers the bus side.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      for (int i = 0; i < NSLOT; i++)
        bank_q[i] <= RST_VALS[i];
      irqMask_q <= '0;
      prdata_q <= 32'h00000000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end
    else
    begin
      bank_q <= bank_d;
      irqMask_q <= irqMask_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  // ----------------------------------------------------------------------
  // Start phase and millisecond timer
  // ----------------------------------------------------------------------
  // Tracks the start phase of each run in whole milliseconds.
  always_comb
  begin
    phase_d = phase_q;
    msCnt_d = msCnt_q;
    tickCnt_d = msTick ? 32'h00000000 : tickCnt_q + 32'h00000001;
    unique case (phase_q)
      ST_IDLE:
        if (runActive)
        begin
          phase_d = ST_START;
          msCnt_d = 16'h0000;
          tickCnt_d = 32'h00000000;
        end
      ST_START:
        if (!runActive)
          phase_d = ST_IDLE;
        else if (msCnt_q >= bank_q[SLOT_STIME])
          phase_d = ST_RUN;
        else if (msTick)
          msCnt_d = msCnt_q + 16'h0001;
      ST_RUN:
        if (!runActive)
          phase_d = ST_IDLE;
      default:
        phase_d = ST_IDLE;
    endcase
  end

  // Registers the phase tracker.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      phase_q <= ST_IDLE;
      msCnt_q <= 16'h0000;
      tickCnt_q <= 32'h00000000;
    end
    else
    begin
      phase_q <= phase_d;
      msCnt_q <= msCnt_d;
      tickCnt_q <= tickCnt_d;
    end
  end

  // ----------------------------------------------------------------------
  // Motion outputs
  // ----------------------------------------------------------------------
  assign tgtRpm = !runActive ? 16'h0000 :
                  manualRun ? bank_q[SLOT_MANSPD] : bank_q[SLOT_POSSPD];
  assign tgtMrpm = 32'(tgtRpm * MRPM_PER_RPM);
  assign posDiff = {cmdPos[31], cmdPos} - {actPos[31], actPos};
  assign posMag = posDiff[32] ? -posDiff : posDiff;

  // Computes the drive-facing values each cycle.
  always_comb
  begin
    dragErr_d = posMag > {17'h00000, bank_q[SLOT_DRAG]};
    readj_d = (bank_q[SLOT_READJ] == 16'h0001);
    // Correction stays within plus or minus the limit.
    if (corrRequest > $signed(bank_q[SLOT_CORR]))
      corr_d = $signed(bank_q[SLOT_CORR]);
    else if (corrRequest < -$signed(bank_q[SLOT_CORR]))
      corr_d = -$signed(bank_q[SLOT_CORR]);
    else
      corr_d = corrRequest;
    abort_d = 16'((32'(tgtRpm) * 32'(bank_q[SLOT_ABORT])) / 32'(PCT_FULL));
    // Speed moves toward the cap once per millisecond by rate milli-rpm.
    speed_d = speed_q;
    if (msTick && speed_q < tgtMrpm)
      speed_d = (tgtMrpm - speed_q > 32'(bank_q[SLOT_ACCEL])) ?
                speed_q + 32'(bank_q[SLOT_ACCEL]) : tgtMrpm;
    else if (msTick && speed_q > tgtMrpm)
      speed_d = (speed_q - tgtMrpm > 32'(bank_q[SLOT_DECEL])) ?
                speed_q - 32'(bank_q[SLOT_DECEL]) : tgtMrpm;
    startPh_d = (phase_d == ST_START);
    tqLim_d = startPh_d ? bank_q[SLOT_STQ] : bank_q[SLOT_RTQ];
    tqCmd_d = (torqueDemand > tqLim_d) ? tqLim_d : torqueDemand;
    jogStb_d = jogEvent;
    jogDist_d = jogEvent ? bank_q[SLOT_JOG] : jogDist_q;
  end

  // Registers the drive outputs and the two-stage key synchroniser.
  // Only the second synchroniser stage feeds the edge detect.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      dragErr_q <= 1'b0;
      readj_q <= 1'b0;
      corr_q <= 16'h0000;
      abort_q <= 16'h0000;
      speed_q <= 32'h00000000;
      startPh_q <= 1'b0;
      tqLim_q <= 16'h0000;
      tqCmd_q <= 16'h0000;
      jogStb_q <= 1'b0;
      jogDist_q <= 16'h0000;
      jogMeta_q <= 1'b0;
      jogSync_q <= 1'b0;
      jogPrev_q <= 1'b0;
    end
    else
    begin
      dragErr_q <= dragErr_d;
      readj_q <= readj_d;
      corr_q <= corr_d;
      abort_q <= abort_d;
      speed_q <= speed_d;
      startPh_q <= startPh_d;
      tqLim_q <= tqLim_d;
      tqCmd_q <= tqCmd_d;
      jogStb_q <= jogStb_d;
      jogDist_q <= jogDist_d;
      jogMeta_q <= jogKeyPin;
      jogSync_q <= jogMeta_q;
      jogPrev_q <= jogSync_q;
    end
  end

  // ----------------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------------
  // Sticky events; a new event wins over a write-one-to-clear in the same cycle.
  always_comb
  begin
    irqStat_d = irqStat_q;
    if (wrDone && slot == SLOT_IRQS)
      irqStat_d = irqStat_q & ~pwdata[IRQ_W-1:0];
    if (dragErr_d && !dragErr_q)
      irqStat_d[IRQ_DRAG] = 1'b1;
    if (phase_q == ST_START && phase_d == ST_RUN)
      irqStat_d[IRQ_START_DONE] = 1'b1;
    if (jogEvent)
      irqStat_d[IRQ_JOG] = 1'b1;
    irq_d = |(irqStat_d & irqMask_d);
  end

  // Registers the interrupt state.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      irqStat_q <= '0;
      irq_q <= 1'b0;
    end
    else
    begin
      irqStat_q <= irqStat_d;
      irq_q <= irq_d;
    end
  end

  // Outputs straight from flip-flops.
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign dragError = dragErr_q;
  assign readjustEnable = readj_q;
  assign speedCorr = corr_q;
  assign speedCmdMrpm = speed_q;
  assign abortSpeedRpm = abort_q;
  assign torqueLimit = tqLim_q;
  assign torqueCmd = tqCmd_q;
  assign startPhase = startPh_q;
  assign jogStrobe = jogStb_q;
  assign jogDistance = jogDist_q;
  assign irq = irq_q;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence s_corrWrMoving;
    wrDone && slot == SLOT_CORR && !atStandstill;
  endsequence
  sequence s_runStart;
    !runActive ##1 runActive;
  endsequence
  property p_drag;
    posMag > {17'h00000, bank_q[SLOT_DRAG]} |=> dragError;
  endproperty
  a_drag: assert property (p_drag) else $error("Drag flag missing.");
  property p_readj;
    bank_q[SLOT_READJ] == 16'h0000 |=> !readjustEnable;
  endproperty
  a_readj: assert property (p_readj) else $error("Readjust on while off.");
  property p_corr;
    ##1 (speedCorr <= $signed($past(bank_q[SLOT_CORR])))
      && (speedCorr >= -$signed($past(bank_q[SLOT_CORR])));
  endproperty
  a_corr: assert property (p_corr) else $error("Correction over limit.");
  property p_corrLock;
    s_corrWrMoving |=> $stable(bank_q[SLOT_CORR]);
  endproperty
  a_corrLock: assert property (p_corrLock) else $error("Limit changed moving.");
  property p_jog;
    jogEvent |=> jogStrobe && jogDistance == $past(bank_q[SLOT_JOG]);
  endproperty
  a_jog: assert property (p_jog) else $error("Jog step wrong.");
  property p_abort;
    !runActive ##1 !runActive |=> abortSpeedRpm == 16'h0000;
  endproperty
  a_abort: assert property (p_abort) else $error("Abort speed nonzero idle.");
  property p_ramp;
    speed_q < tgtMrpm |=> speedCmdMrpm <= $past(speed_q) + 32'($past(bank_q[SLOT_ACCEL]));
  endproperty
  a_ramp: assert property (p_ramp) else $error("Ramp step too large.");
  property p_startTq;
    s_runStart |=> startPhase && torqueLimit == $past(bank_q[SLOT_STQ]);
  endproperty
  a_startTq: assert property (p_startTq) else $error("No start torque.");
  property p_tqClamp;
    torqueCmd <= torqueLimit;
  endproperty
  a_tqClamp: assert property (p_tqClamp) else $error("Torque over limit.");
endmodule

// ==== tb/dmps_ctrl_model.sv ====
/*
  Fieldbus controller model: an APB master that reads and writes the motion parameters.
  Assumes the caller enters each transfer just after a rising edge of clk.
*/
`timescale 1ns/10ps
module dmps_ctrl_model
  import dmps_pkg::*;
(
  // Clock.
  input wire logic clk,
  // Requests towards the block.
  output logic [11:0] paddr,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [31:0] pwdata,
  // Answers from the block.
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  // The bus starts idle.
  initial
  begin
    paddr = 12'h000;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    pwdata = 32'h00000000;
  end

  // ----------------------------------------
  // One transfer: setup, access until pready, then an idle cycle.
  // ----------------------------------------
  task automatic xfer(input logic wr, input logic [7:0] idx, input logic [31:0] wdata,
    output logic [31:0] rdata, output logic err, output logic hung);
    int n;
    begin
      hung = 1'b1;
      rdata = 32'h00000000;
      err = 1'b0;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {2'h0, idx, 2'h0};
      pwdata <= wdata;
      @(posedge clk);
      penable <= 1'b1;
      // Request is held until pready is seen; data is taken at that edge.
      for (n = 0; n < 20 && hung; n++)
      begin
        @(posedge clk);
        if (pready === 1'b1)
        begin
          hung = 1'b0;
          rdata = prdata;
          err = pslverr;
        end
      end
      psel <= 1'b0;
      penable <= 1'b0;
      // Released data lines do not keep the last value.
      pwdata <= ~wdata;
      @(posedge clk);
    end
  endtask
endmodule

// ==== tb/tb_top.sv ====
/*
  Self-checking bench for the motion parameter set, driven through the controller model.
  Assumes a shortened millisecond tick of 10 cycles so start phase and ramps stay short.
*/
`timescale 1ns/10ps
module tb_top;
  import dmps_pkg::*;
  // Bench-side signals, one per design port.
  logic clk, sys_rst, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, speedCmdMrpm, prevSpd;
  logic signed [31:0] cmdPos, actPos;
  logic runActive, manualRun, atStandstill, jogKeyPin, jogBit;
  logic signed [15:0] corrRequest, speedCorr;
  logic [15:0] torqueDemand, abortSpeedRpm, torqueLimit, torqueCmd, jogDistance, jogSeen;
  logic dragError, readjustEnable, startPhase, jogStrobe, irq;
  logic [31:0] d;
  logic e;
  int failures = 0, checksDone = 0, jogCount = 0, n;
  logic [31:0] maxUp = 32'h0, maxDown = 32'h0;
  // Register indices in the order of the reset value table.
  localparam logic [7:0] IDX_TAB [NSLOT] = '{IDX_DRAG_THR, IDX_READJUST, IDX_CORR_LIM,
    IDX_JOG_STEP, IDX_POS_SPEED, IDX_MAN_SPEED, IDX_ABORT_PCT, IDX_ACCEL, IDX_DECEL,
    IDX_START_TQ, IDX_RUN_TQ, IDX_START_TIME};

  // Design under test with a 10-cycle millisecond.
  dmps_motion_params #(.ADDR_W(12), .TICK_CYCLES(10)) i_dut (.clk(clk), .sys_rst(sys_rst),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .cmdPos(cmdPos), .actPos(actPos),
    .runActive(runActive), .manualRun(manualRun), .atStandstill(atStandstill),
    .corrRequest(corrRequest), .torqueDemand(torqueDemand), .jogKeyPin(jogKeyPin),
    .jogBit(jogBit), .dragError(dragError), .readjustEnable(readjustEnable),
    .speedCorr(speedCorr), .speedCmdMrpm(speedCmdMrpm), .abortSpeedRpm(abortSpeedRpm),
    .torqueLimit(torqueLimit), .torqueCmd(torqueCmd), .startPhase(startPhase),
    .jogStrobe(jogStrobe), .jogDistance(jogDistance), .irq(irq));

  // Controller model on the register bus.
  dmps_ctrl_model i_ctrl (.clk(clk), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  // Free-running clock at 8 ns.
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Track jog strobes and the largest speed steps up and down.
  always @(posedge clk)
  begin
    prevSpd <= speedCmdMrpm;
    if (jogStrobe === 1'b1)
    begin
      jogCount <= jogCount + 1;
      jogSeen <= jogDistance;
    end
    if (!sys_rst && speedCmdMrpm > prevSpd && speedCmdMrpm - prevSpd > maxUp)
      maxUp <= speedCmdMrpm - prevSpd;
    if (!sys_rst && speedCmdMrpm < prevSpd && prevSpd - speedCmdMrpm > maxDown)
      maxDown <= prevSpd - speedCmdMrpm;
  end

  // ----------------------------------------
  // Verdict, comparison and bus helpers.
  // ----------------------------------------
  task automatic summarize();
    $display("checks %0d failures %0d", checksDone, failures);
    if (failures == 0 && checksDone > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    checksDone++;
    if (got !== exp)
    begin
      failures++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  // A hung transfer counts as a mismatch and ends the run.
  task automatic access(input logic wr, input logic [7:0] idx, input logic [15:0] val);
    logic h;
    i_ctrl.xfer(wr, idx, {16'h0000, val}, d, e, h);
    if (h)
    begin
      failures++;
      $display("mismatch pready expected 1 seen 0");
      summarize();
    end
  endtask

  task automatic wr(input logic [7:0] idx, input logic [15:0] val);
    access(1'b1, idx, val);
  endtask

  task automatic rdChk(input string name, input logic [7:0] idx, input logic [15:0] exp);
    access(1'b0, idx, 16'h0000);
    check(name, {16'h0000, exp}, d);
  endtask

  task automatic step(input int cyc);
    repeat (cyc) @(posedge clk);
  endtask

  // Hang guard for the whole run.
  initial
  begin
    step(20000);
    failures++;
    summarize();
  end

  // ----------------------------------------
  // Main sequence.
  // ----------------------------------------
  initial
  begin
    sys_rst = 1'b1;
    cmdPos = 32'sh0;
    actPos = 32'sh0;
    runActive = 1'b0;
    manualRun = 1'b0;
    atStandstill = 1'b1;
    corrRequest = 16'sh0;
    torqueDemand = 16'h0000;
    jogKeyPin = 1'b0;
    jogBit = 1'b0;
    step(10);
    sys_rst <= 1'b0;
    step(1);
    for (int i = 0; i < NSLOT; i++)
      rdChk("reset value", IDX_TAB[i], RST_VALS[i]);
    // Idle motion word: phase idle, axis at standstill.
    rdChk("motion idle", IDX_MOTION, 16'h0003);
    access(1'b0, 8'h20, 16'h0000);
    check("unmapped error", 32'h1, {31'h0, e});
    check("unmapped data", 32'h0, d);
    // Drag error just at and just above the threshold.
    wr(IDX_DRAG_THR, 16'h0005);
    actPos <= 32'sh5;
    step(3);
    check("dragError at limit", 32'h0, {31'h0, dragError});
    actPos <= -32'sh6;
    step(3);
    check("dragError above", 32'h1, {31'h0, dragError});
    check("irq masked", 32'h0, {31'h0, irq});
    wr(IDX_IRQ_MASK, 16'h0007);
    step(2);
    check("irq unmasked", 32'h1, {31'h0, irq});
    rdChk("irq mask", IDX_IRQ_MASK, 16'h0007);
    actPos <= 32'sh0;
    wr(IDX_IRQ_STAT, 16'h0001);
    step(2);
    check("irq cleared", 32'h0, {31'h0, irq});
    // Readjustment on and off.
    for (int v = 1; v >= 0; v--)
    begin
      wr(IDX_READJUST, 16'(v));
      step(2);
      check("readjustEnable", 32'(v), {31'h0, readjustEnable});
    end
    // Correction clamp, then a write while moving.
    wr(IDX_CORR_LIM, 16'h0003);
    corrRequest <= 16'sh000A;
    step(3);
    check("speedCorr high", 32'h3, {16'h0000, speedCorr});
    corrRequest <= -16'sh000A;
    step(3);
    check("speedCorr low", 32'h0000FFFD, {16'h0000, speedCorr});
    atStandstill <= 1'b0;
    wr(IDX_CORR_LIM, 16'h0007);
    rdChk("limit kept", IDX_CORR_LIM, 16'h0003);
    // Jog by bit and by key.
    wr(IDX_JOG_STEP, 16'h0005);
    jogBit <= 1'b1;
    step(1);
    jogBit <= 1'b0;
    step(8);
    jogKeyPin <= 1'b1;
    step(8);
    jogKeyPin <= 1'b0;
    step(8);
    check("jog count", 32'h2, 32'(jogCount));
    check("jog distance", 32'h5, {16'h0000, jogSeen});
    rdChk("jog event", IDX_IRQ_STAT, 16'h0004);
    wr(IDX_IRQ_STAT, 16'h0004);
    // Positioning run with start phase, torque caps and ramps.
    wr(IDX_START_TQ, 16'h0032);
    wr(IDX_RUN_TQ, 16'h0050);
    wr(IDX_START_TIME, 16'h0002);
    wr(IDX_POS_SPEED, 16'h000A);
    wr(IDX_MAN_SPEED, 16'h0014);
    wr(IDX_ACCEL, 16'h0FA0);
    wr(IDX_DECEL, 16'h07D0);
    wr(IDX_ABORT_PCT, 16'h0032);
    torqueDemand <= 16'h00C8;
    runActive <= 1'b1;
    step(3);
    check("startPhase", 32'h1, {31'h0, startPhase});
    check("start torque", 32'h32, {16'h0000, torqueLimit});
    check("start torqueCmd", 32'h32, {16'h0000, torqueCmd});
    for (n = 3; n < 60 && startPhase === 1'b1; n++)
      step(1);
    check("start length", 32'h1, {31'h0, n >= 19 && n <= 23});
    step(2);
    check("run torque", 32'h50, {16'h0000, torqueLimit});
    check("run torqueCmd", 32'h50, {16'h0000, torqueCmd});
    rdChk("start done", IDX_IRQ_STAT, 16'h0002);
    check("abort speed", 32'h5, {16'h0000, abortSpeedRpm});
    for (n = 0; n < 100 && speedCmdMrpm !== 32'h00002710; n++)
      step(1);
    step(20);
    check("position speed", 32'h00002710, speedCmdMrpm);
    check("accel step", 32'h00000FA0, maxUp);
    // Manual run, then stop and ramp down.
    manualRun <= 1'b1;
    torqueDemand <= 16'h003C;
    step(60);
    check("manual speed", 32'h00004E20, speedCmdMrpm);
    check("manual abort", 32'hA, {16'h0000, abortSpeedRpm});
    check("low torqueCmd", 32'h3C, {16'h0000, torqueCmd});
    runActive <= 1'b0;
    manualRun <= 1'b0;
    step(150);
    check("stopped speed", 32'h0, speedCmdMrpm);
    check("decel step", 32'h000007D0, maxDown);
    summarize();
  end
endmodule
